/* File: verilog/adc_conversion_control.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - select code routes pins, dac, temperature, ground
// RL2 - selection changes apply after running conversion
// RL3 - writing start bit launches one measurement
// RL4 - start bit reads one while busy
// RL5 - enabled event input starts a conversion
// RL6 - enable bits: window bit1, result bit0
// RL7 - window flag set on matching complete result
// RL8 - result flag set on every completion
// RL9 - flags clear on write one or result read
// RL10 - debug halt freezes block unless run bit
// RL11 - shared eight-bit latch for wide access
// RL12 - result read-only, low then high byte
// RL13 - raw sample saturates at 0x3ff and 0x000
// RL14 - accumulated result never exceeds 0xffc0
// RL15 - raw ten bits sit in low bits
// RL16 - window compares final accumulated value only
// RL17 - window mode encodings none/below/above/inside/outside
// RL18 - accumulate two to the n samples
// RL19 - low byte access goes through the latch
// RL20 - irq line per source, flag and enable
module adc_conversion_control (
	input  wire logic                         clk_i,          // peripheral clock
	input  wire logic                         rst_i,          // sync reset, high
	input  wire logic                         cyc_i,          // wishbone cycle
	input  wire logic                         stb_i,          // wishbone strobe
	input  wire logic                         we_i,           // wishbone write
	input  wire logic [7:0]                   adr_i,          // byte address
	input  wire logic [3:0]                   sel_i,          // byte lanes
	input  wire logic [31:0]                  dat_i,          // write data
	output logic      [31:0]                  dat_o,          // read data
	output logic                              ack_o,          // wishbone ack
	input  wire logic                         event_i,        // start event pulse
	input  wire logic                         debug_halt_i,   // cpu in break debug
	output logic                              sample_req_o,   // converter request
	input  wire logic                         sample_done_i,  // converter sample ready
	input  wire logic [adc_ctrl_pkg::RAW_W-1:0] sample_data_i, // raw sample
	input  wire logic                         over_range_i,   // input above reference
	input  wire logic                         under_range_i,  // input below zero
	output logic [adc_ctrl_pkg::SELECT_W-1:0] channel_o,      // applied select code
	output logic      [15:0]                  pin_select_o,   // one-hot pin route
	output logic                              dac_reference_input_o, // dac route
	output logic                              temperature_input_o,   // sensor route
	output logic                              ground_select_o,       // ground route
	output logic      [7:0]                   trim_setting_o, // trim byte
	output logic                              irq_result_o,   // result irq
	output logic                              irq_window_o    // window irq
);
	import adc_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_limit_low(input logic [5:0] idx);
		is_limit_low = (idx == IDX_WIN_LOW) || (idx == IDX_WIN_HIGH);
	endfunction : is_limit_low

	function automatic logic is_pair_low(input logic [5:0] idx);
		is_pair_low = is_limit_low(idx) || (idx == IDX_RESULT);
	endfunction : is_pair_low

	function automatic logic window_hit(input logic [2:0]  mode,
	                                    input logic [15:0] value,
	                                    input logic [15:0] low,
	                                    input logic [15:0] high);
		case (mode)
			WIN_BELOW:   window_hit = value < low;                        // RL17
			WIN_ABOVE:   window_hit = value > high;                       // RL17
			WIN_INSIDE:  window_hit = (value > low) && (value < high);    // RL17
			WIN_OUTSIDE: window_hit = (value < low) || (value > high);    // RL17
			default:     window_hit = 1'b0;
		endcase
	endfunction : window_hit

	////////////////////////////////////////////////////////////////////////////////
	// state

	conv_state_e                state;
	logic                       free_running;
	logic [ACCUM_W-1:0]         accumulation_count;
	logic [WINDOW_MODE_W-1:0]   window_mode;
	logic [SELECT_W-1:0]        input_select;
	logic                       event_start_enable;
	logic [1:0]                 irq_enable;
	logic [1:0]                 irq_flags;
	logic                       run_while_halted;
	logic [7:0]                 wide_access_latch;
	logic [15:0]                conversion_result;
	logic [15:0]                window_low_limit;
	logic [15:0]                window_high_limit;
	logic [SELECT_W-1:0]        applied_select;
	logic [COUNT_W-1:0]         sample_count;
	logic [15:0]                accumulator;

	logic                       req;
	logic                       wr;
	logic                       rd;
	logic [5:0]                 idx;
	logic [7:0]                 wdat;
	logic [7:0]                 rd_byte;
	logic [7:0]                 pair_high;
	logic                       running;
	logic                       busy;
	logic                       launch;
	logic                       last_sample;
	logic                       finish;
	logic [COUNT_W-1:0]         samples_needed;
	logic [RAW_W-1:0]           clamped;
	logic [16:0]                acc_sum;
	logic [15:0]                next_acc;
	logic [1:0]                 next_flags;

	////////////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, ack one cycle, every address answered

	assign req  = cyc_i && stb_i && !ack_o;
	assign wr   = req && we_i && sel_i[0];
	assign rd   = req && !we_i;
	assign idx  = adr_i[7:2];
	assign wdat = dat_i[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			free_running       <= 1'b0;
			accumulation_count <= ACCUM_W'(BYTE_RESET);
			window_mode        <= WINDOW_MODE_W'(BYTE_RESET);
			input_select       <= SELECT_W'(BYTE_RESET);
			event_start_enable <= 1'b0;
			irq_enable         <= 2'h0;
			run_while_halted   <= 1'b0;
			trim_setting_o     <= TRIM_RESET;
		end else if (wr) begin
			if (idx == IDX_RUN_CONTROL) begin
				free_running <= wdat[FREE_RUN_BIT];
			end else if (idx == IDX_ACCUM) begin
				accumulation_count <= wdat[ACCUM_W-1:0];
			end else if (idx == IDX_WINDOW_MODE) begin
				window_mode <= wdat[WINDOW_MODE_W-1:0];
			end else if (idx == IDX_INPUT_SELECT) begin
				input_select <= wdat[SELECT_W-1:0];
			end else if (idx == IDX_EVENT) begin
				event_start_enable <= wdat[EVENT_START_BIT];
			end else if (idx == IDX_IRQ_ENABLE) begin
				irq_enable[IRQ_WINDOW_BIT] <= wdat[IRQ_WINDOW_BIT]; // RL6
				irq_enable[IRQ_RESULT_BIT] <= wdat[IRQ_RESULT_BIT]; // RL6
			end else if (idx == IDX_HALT) begin
				run_while_halted <= wdat[RUN_HALTED_BIT];
			end else if (idx == IDX_TRIM) begin
				trim_setting_o <= wdat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sixteen-bit access through the shared latch

	always_comb begin
		if (idx == IDX_RESULT) begin
			pair_high = conversion_result[15:8];
		end else if (idx == IDX_WIN_LOW) begin
			pair_high = window_low_limit[15:8];
		end else begin
			pair_high = window_high_limit[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wide_access_latch <= BYTE_RESET;
		end else if (wr && ((idx == IDX_LATCH) || is_limit_low(idx))) begin
			wide_access_latch <= wdat; // RL11 RL19
		end else if (rd && is_pair_low(idx)) begin
			wide_access_latch <= pair_high; // RL19
		end
	end

	// high-byte write commits both bytes at once so the comparator never sees half a limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			window_low_limit  <= WORD_RESET;
			window_high_limit <= WORD_RESET;
		end else if (wr && (idx == IDX_WIN_LOW + IDX_HIGH_BYTE)) begin
			window_low_limit <= {wdat, wide_access_latch}; // RL19
		end else if (wr && (idx == IDX_WIN_HIGH + IDX_HIGH_BYTE)) begin
			window_high_limit <= {wdat, wide_access_latch}; // RL19
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		rd_byte = BYTE_RESET;
		if (idx == IDX_RUN_CONTROL) begin
			rd_byte[FREE_RUN_BIT] = free_running;
			rd_byte[START_BIT]    = busy; // RL4
		end else if (idx == IDX_ACCUM) begin
			rd_byte[ACCUM_W-1:0] = accumulation_count;
		end else if (idx == IDX_WINDOW_MODE) begin
			rd_byte[WINDOW_MODE_W-1:0] = window_mode;
		end else if (idx == IDX_INPUT_SELECT) begin
			rd_byte[SELECT_W-1:0] = input_select;
		end else if (idx == IDX_TRIGGER) begin
			rd_byte[START_BIT] = busy; // RL4
		end else if (idx == IDX_EVENT) begin
			rd_byte[EVENT_START_BIT] = event_start_enable;
		end else if (idx == IDX_IRQ_ENABLE) begin
			rd_byte[1:0] = irq_enable;
		end else if (idx == IDX_IRQ_FLAGS) begin
			rd_byte[1:0] = irq_flags;
		end else if (idx == IDX_HALT) begin
			rd_byte[RUN_HALTED_BIT] = run_while_halted;
		end else if (idx == IDX_LATCH) begin
			rd_byte = wide_access_latch;
		end else if (idx == IDX_RESULT) begin
			rd_byte = conversion_result[7:0]; // RL12
		end else if (idx == IDX_WIN_LOW) begin
			rd_byte = window_low_limit[7:0];
		end else if (idx == IDX_WIN_HIGH) begin
			rd_byte = window_high_limit[7:0];
		end else if ((idx == IDX_RESULT + IDX_HIGH_BYTE) ||
		             (idx == IDX_WIN_LOW + IDX_HIGH_BYTE) ||
		             (idx == IDX_WIN_HIGH + IDX_HIGH_BYTE)) begin
			rd_byte = wide_access_latch; // RL12 RL19
		end else if (idx == IDX_TRIM) begin
			rd_byte = trim_setting_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			dat_o <= {24'h00_0000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencing

	assign running = !debug_halt_i || run_while_halted; // RL10
	assign busy    = (state != ST_IDLE);
	assign launch  = running && !busy &&
	                 ((wr && (idx == IDX_TRIGGER) && wdat[START_BIT]) || // RL3
	                  (event_start_enable && event_i));                  // RL5 RL10

	// reserved code 7 falls back to a single sample
	assign samples_needed = (accumulation_count > ACC_MAX_CODE) ? COUNT_W'(1) :
	                        COUNT_W'(COUNT_W'(1) << accumulation_count); // RL18
	assign last_sample    = (sample_count == samples_needed - COUNT_W'(1));
	assign finish         = running && (state == ST_SAMPLE) && sample_done_i && last_sample;

	// range flags override the sample so an out-of-range input still lands on a rail
	assign clamped  = over_range_i  ? RAW_MAX :
	                  under_range_i ? RAW_MIN : sample_data_i; // RL13
	assign acc_sum  = {1'b0, accumulator} + {7'h00, clamped}; // RL15
	assign next_acc = (acc_sum > {1'b0, ACC_LIMIT}) ? ACC_LIMIT : acc_sum[15:0]; // RL14

	assign sample_req_o = running && (state == ST_SAMPLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state        <= ST_IDLE;
			sample_count <= COUNT_W'(0);
			accumulator  <= WORD_RESET;
		end else if (running) begin
			case (state)
				ST_IDLE: begin
					if (launch) begin
						state        <= ST_SAMPLE; // RL3
						sample_count <= COUNT_W'(0);
						accumulator  <= WORD_RESET;
					end
				end
				ST_SAMPLE: begin
					if (sample_done_i && last_sample) begin
						sample_count <= COUNT_W'(0);
						accumulator  <= WORD_RESET;
						if (!free_running) begin
							state <= ST_IDLE; // RL4
						end
					end else if (sample_done_i) begin
						sample_count <= sample_count + COUNT_W'(1); // RL18
						accumulator  <= next_acc;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_result <= WORD_RESET;
		end else if (finish) begin
			conversion_result <= next_acc; // RL15 RL18
		end
	end

	// selection is taken only between conversions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			applied_select <= SELECT_W'(BYTE_RESET);
		end else if (!busy || finish) begin
			applied_select <= input_select; // RL2
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_o             <= SELECT_W'(BYTE_RESET);
			pin_select_o          <= 16'h0000;
			dac_reference_input_o <= 1'b0;
			temperature_input_o   <= 1'b0;
			ground_select_o       <= 1'b0;
		end else begin
			channel_o <= applied_select;
			for (int i = 0; i < 16; i++) begin
				pin_select_o[i] <= (applied_select <= SEL_PIN_LAST) &&
				                   (applied_select[3:0] == 4'(i)); // RL1
			end
			dac_reference_input_o <= (applied_select == SEL_DAC);  // RL1
			temperature_input_o   <= (applied_select == SEL_TEMP); // RL1
			ground_select_o       <= (applied_select == SEL_GND);  // RL1
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags: a completion in the same cycle as a clear leaves the flag set

	always_comb begin
		next_flags = irq_flags;
		if (wr && (idx == IDX_IRQ_FLAGS)) begin
			next_flags = irq_flags & ~wdat[1:0]; // RL9
		end
		if (rd && ((idx == IDX_RESULT) || (idx == IDX_RESULT + IDX_HIGH_BYTE))) begin
			next_flags = 2'h0; // RL9
		end
		if (finish) begin
			next_flags[IRQ_RESULT_BIT] = 1'b1; // RL8
			if (window_hit(window_mode, next_acc, window_low_limit, window_high_limit)) begin
				next_flags[IRQ_WINDOW_BIT] = 1'b1; // RL7 RL16
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flags <= 2'h0;
		end else begin
			irq_flags <= next_flags;
		end
	end

	assign irq_result_o = irq_flags[IRQ_RESULT_BIT] && irq_enable[IRQ_RESULT_BIT]; // RL20
	assign irq_window_o = irq_flags[IRQ_WINDOW_BIT] && irq_enable[IRQ_WINDOW_BIT]; // RL20

endmodule : adc_conversion_control

/* File: verilog/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices; byte address on the bus is four times the index
	localparam logic [5:0] IDX_RUN_CONTROL  = 6'h00;
	localparam logic [5:0] IDX_ACCUM        = 6'h01;
	localparam logic [5:0] IDX_WINDOW_MODE  = 6'h04;
	localparam logic [5:0] IDX_INPUT_SELECT = 6'h06;
	localparam logic [5:0] IDX_TRIGGER      = 6'h08;
	localparam logic [5:0] IDX_EVENT        = 6'h09;
	localparam logic [5:0] IDX_IRQ_ENABLE   = 6'h0a;
	localparam logic [5:0] IDX_IRQ_FLAGS    = 6'h0b;
	localparam logic [5:0] IDX_HALT         = 6'h0c;
	localparam logic [5:0] IDX_LATCH        = 6'h0d;
	localparam logic [5:0] IDX_RESULT       = 6'h10;
	localparam logic [5:0] IDX_WIN_LOW      = 6'h12;
	localparam logic [5:0] IDX_WIN_HIGH     = 6'h14;
	localparam logic [5:0] IDX_TRIM         = 6'h16;
	localparam logic [5:0] IDX_HIGH_BYTE    = 6'h01;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and widths
	localparam int START_BIT        = 0;
	localparam int FREE_RUN_BIT     = 1;
	localparam int EVENT_START_BIT  = 0;
	localparam int IRQ_WINDOW_BIT   = 1;
	localparam int IRQ_RESULT_BIT   = 0;
	localparam int RUN_HALTED_BIT   = 0;
	localparam int SELECT_W         = 5;
	localparam int WINDOW_MODE_W    = 3;
	localparam int ACCUM_W          = 3;
	localparam int RAW_W            = 10;
	localparam int COUNT_W          = 7;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]  BYTE_RESET   = 8'h00;
	localparam logic [7:0]  TRIM_RESET   = 8'h01;
	localparam logic [15:0] WORD_RESET   = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// input selection codes
	localparam logic [4:0] SEL_PIN_LAST = 5'h0f;
	localparam logic [4:0] SEL_DAC      = 5'h1c;
	localparam logic [4:0] SEL_TEMP     = 5'h1e;
	localparam logic [4:0] SEL_GND      = 5'h1f;

	////////////////////////////////////////////////////////////////////////////////
	// window modes and accumulation
	localparam logic [2:0] WIN_NONE    = 3'h0;
	localparam logic [2:0] WIN_BELOW   = 3'h1;
	localparam logic [2:0] WIN_ABOVE   = 3'h2;
	localparam logic [2:0] WIN_INSIDE  = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;
	localparam logic [2:0] ACC_MAX_CODE = 3'h6;

	localparam logic [9:0]  RAW_MAX   = 10'h3ff;
	localparam logic [9:0]  RAW_MIN   = 10'h000;
	localparam logic [15:0] ACC_LIMIT = 16'hffc0;

	typedef enum logic {
		ST_IDLE,
		ST_SAMPLE
	} conv_state_e;

endpackage : adc_ctrl_pkg

/* File: verif/adc_conversion_control_properties.sv */
`timescale 1ns/1ps
module adc_conversion_control_properties
	import adc_ctrl_pkg::*;
(
	input wire logic                          clk_i,                 // clock
	input wire logic                          rst_i,                 // reset
	input wire logic                          cyc_i,                 // cycle
	input wire logic                          stb_i,                 // strobe
	input wire logic                          we_i,                  // write
	input wire logic [7:0]                    adr_i,                 // address
	input wire logic [3:0]                    sel_i,                 // lanes
	input wire logic [31:0]                   dat_i,                 // wdata
	input wire logic [31:0]                   dat_o,                 // rdata
	input wire logic                          ack_o,                 // ack
	input wire logic                          event_i,               // event
	input wire logic                          debug_halt_i,          // halt
	input wire logic                          sample_req_o,          // request
	input wire logic                          sample_done_i,         // done
	input wire logic [adc_ctrl_pkg::SELECT_W-1:0] channel_o,         // select
	input wire logic [15:0]                   pin_select_o,          // pins
	input wire logic                          dac_reference_input_o, // dac
	input wire logic                          temperature_input_o,   // sensor
	input wire logic                          ground_select_o,       // ground
	input wire logic                          irq_result_o,          // result irq
	input wire logic                          irq_window_o           // window irq
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic        take;
	logic        trig_wr;
	logic        en_wr;
	logic [18:0] route;
	assign take = cyc_i && stb_i && !ack_o;
	assign trig_wr = take && we_i && sel_i[0] && adr_i[7:2] == IDX_TRIGGER && dat_i[START_BIT];
	assign en_wr = take && we_i && adr_i[7:2] == IDX_IRQ_ENABLE;
	assign route = {pin_select_o, dac_reference_input_o, temperature_input_o, ground_select_o};

	function automatic logic [18:0] route_of(input logic [4:0] c);
		route_of = {(c <= SEL_PIN_LAST) ? 16'h0001 << c : 16'h0000, c == SEL_DAC, c == SEL_TEMP,
			c == SEL_GND};
	endfunction : route_of

	a_ack_follows: assert property (take |=> ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(take))
		else $error("ack without request");
	a_read_hold: assert property (!$past(take && !we_i) |-> $stable(dat_o))
		else $error("read data moved without a read");
	// three stable samples, though the route outputs register in the same cycle as channel_o
	a_route_match: assert property ($stable(channel_o) [*3] |-> route == route_of(channel_o))
		else $error("route does not follow select");
	a_route_onehot: assert property ($onehot0(route))
		else $error("more than one route active");
	a_req_holds: assert property (sample_req_o && !sample_done_i ##1 !debug_halt_i |-> sample_req_o)
		else $error("request dropped before sample");
	a_req_cause: assert property ($rose(sample_req_o) |-> $past(trig_wr || event_i || debug_halt_i))
		else $error("conversion started without cause");
	a_irq_res_cause: assert property ($rose(irq_result_o) |-> $past(sample_done_i || en_wr))
		else $error("result irq without cause");
	a_irq_win_cause: assert property ($rose(irq_window_o) |-> $past(sample_done_i || en_wr))
		else $error("window irq without cause");
	a_irq_clear_cause: assert property ($fell(irq_result_o) |-> $past(take))
		else $error("result irq cleared without access");

	c_trigger: cover property (trig_wr ##1 sample_req_o);
	c_window: cover property ($rose(irq_window_o));
	c_halt_run: cover property (debug_halt_i && sample_req_o);
endmodule : adc_conversion_control_properties

bind adc_conversion_control adc_conversion_control_properties chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
	.debug_halt_i(debug_halt_i), .sample_req_o(sample_req_o), .sample_done_i(sample_done_i),
	.channel_o(channel_o), .pin_select_o(pin_select_o),
	.dac_reference_input_o(dac_reference_input_o), .temperature_input_o(temperature_input_o),
	.ground_select_o(ground_select_o), .irq_result_o(irq_result_o), .irq_window_o(irq_window_o));

/* File: verif/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
	import adc_ctrl_pkg::*;
	logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, event_i, debug_halt_i;
	logic                sample_req_o, sample_done_i, over_range_i, under_range_i;
	logic                dac, temp, gnd, irq_r, irq_w;
	logic [7:0]          adr_i, trim;
	logic [3:0]          sel_i;
	logic [31:0]         dat_i, dat_o;
	logic [RAW_W-1:0]    sample_data_i;
	logic [SELECT_W-1:0] channel_o;
	logic [15:0]         pin_select_o;
	logic [18:0]         route;
	logic [1:0]          irqs;
	int                  num_errors, tests_run;
	assign route = {pin_select_o, dac, temp, gnd};
	assign irqs = {irq_w, irq_r};

	adc_conversion_control dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
		.debug_halt_i(debug_halt_i), .sample_req_o(sample_req_o), .sample_done_i(sample_done_i),
		.sample_data_i(sample_data_i), .over_range_i(over_range_i), .under_range_i(under_range_i),
		.channel_o(channel_o), .pin_select_o(pin_select_o), .dac_reference_input_o(dac),
		.temperature_input_o(temp), .ground_select_o(gnd), .trim_setting_o(trim),
		.irq_result_o(irq_r), .irq_window_o(irq_w));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task stall;
		num_errors++;
		$display("mismatch wait exp 1 got 0");
		end_of_test;
	endtask : stall

	task bus(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {i, 2'b00};
		dat_i <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (k >= 20) stall;
	endtask : bus

	task wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] s;
		bus(1'b1, i, d, s);
	endtask : wr

	task rd(input logic [5:0] i, output logic [7:0] q);
		bus(1'b0, i, 8'h00, q);
	endtask : rd

	// low byte first: the high byte comes through the shared latch
	task rd16(input logic [5:0] i, output logic [15:0] v);
		rd(i, v[7:0]);
		rd(i + IDX_HIGH_BYTE, v[15:8]);
	endtask : rd16

	task wr16(input logic [5:0] i, input logic [15:0] v);
		wr(i, v[7:0]);
		wr(i + IDX_HIGH_BYTE, v[15:8]);
	endtask : wr16

	function automatic logic [18:0] route_of(input logic [4:0] c);
		route_of = {(c <= SEL_PIN_LAST) ? 16'h0001 << c : 16'h0000, c == SEL_DAC, c == SEL_TEMP,
			c == SEL_GND};
	endfunction : route_of

	function automatic logic win_of(input logic [2:0] m, input logic [15:0] v, l, h);
		case (m)
			WIN_BELOW: win_of = v < l;
			WIN_ABOVE: win_of = v > h;
			WIN_INSIDE: win_of = v > l && v < h;
			WIN_OUTSIDE: win_of = v < l || v > h;
			default: win_of = 1'b0;
		endcase
	endfunction : win_of

	task samp(input logic [9:0] d, input logic ov, input logic un);
		int k;
		k = 0;
		#1;
		while (sample_req_o !== 1'b1 && k < 40) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k >= 40) stall;
		@(posedge clk_i);
		sample_done_i <= 1'b1;
		sample_data_i <= d;
		over_range_i <= ov;
		under_range_i <= un;
		@(posedge clk_i);
		sample_done_i <= 1'b0;
		sample_data_i <= ~d;
	endtask : samp

	task conv(input logic [2:0] n, input logic ev, input logic full, output logic [15:0] e);
		logic [16:0] s;
		logic [9:0]  d;
		logic        ov, un;
		logic [7:0]  q;
		s = 17'h0_0000;
		wr(IDX_ACCUM, {5'h00, n});
		if (ev) begin
			@(posedge clk_i);
			event_i <= 1'b1;
			@(posedge clk_i);
			event_i <= 1'b0;
		end else wr(IDX_TRIGGER, 8'h01);
		rd(IDX_TRIGGER, q);
		`CHK("busy", 1'b1, q[0])
		repeat ((n == 3'h0) ? 1 : (1 << n)) begin
			d = full ? RAW_MAX : 10'($urandom);
			ov = !full && ($urandom % 6 == 0);
			un = !full && ($urandom % 6 == 1);
			s = s + (ov ? RAW_MAX : un ? RAW_MIN : d);
			samp(d, ov, un);
		end
		e = (s > ACC_LIMIT) ? ACC_LIMIT : s[15:0];
		rd(IDX_TRIGGER, q);
		`CHK("idle", 1'b0, q[0])
	endtask : conv

	////////////////////////////////
	initial begin
		logic [7:0]  q, f;
		logic [15:0] e, v, lo, hi;
		logic [5:0]  ri [7];
		ri = '{IDX_TRIGGER, IDX_EVENT, IDX_IRQ_ENABLE, IDX_HALT, IDX_RESULT, IDX_TRIM, 6'h3f};
		{cyc_i, stb_i, we_i, event_i, debug_halt_i, sample_done_i} = 6'h00;
		{over_range_i, under_range_i, adr_i, dat_i, sample_data_i} = '0;
		sel_i = 4'h1;
		rst_i = 1'b1;
		num_errors = 0;
		tests_run = 0;
		void'($urandom(32'hc66d_34ec));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ri[j]) begin
			rd(ri[j], q);
			`CHK("reset", (ri[j] == IDX_TRIM) ? TRIM_RESET : BYTE_RESET, q)
		end
		wr(IDX_RESULT, 8'hff);
		rd(IDX_RESULT, q);
		`CHK("result ro", BYTE_RESET, q)
		wr(IDX_LATCH, 8'h5a);
		rd(IDX_LATCH, q);
		`CHK("latch", 8'h5a, q)
		for (int c = 0; c < 32; c++) begin
			wr(IDX_INPUT_SELECT, 8'(c));
			rd(IDX_INPUT_SELECT, q);
			`CHK("route", route_of(5'(c)), route)
		end
		$display("end registers");
		wr(IDX_IRQ_ENABLE, 8'h03);
		for (int m = 0; m < 8; m++) begin
			lo = 16'($urandom);
			hi = 16'($urandom);
			wr16(IDX_WIN_LOW, lo);
			wr16(IDX_WIN_HIGH, hi);
			rd16(IDX_WIN_HIGH, v);
			`CHK("limit", hi, v)
			wr(IDX_WINDOW_MODE, 8'(m));
			conv((m == 7) ? ACC_MAX_CODE : 3'($urandom % 7), 1'b0, m == 7, e);
			f = win_of(3'(m), e, lo, hi) ? 8'h03 : 8'h01;
			rd(IDX_IRQ_FLAGS, q);
			`CHK("flags", f, q)
			`CHK("irq", f[1:0], irqs)
			if (m == 2) begin
				wr(IDX_IRQ_FLAGS, 8'h00);
				rd(IDX_IRQ_FLAGS, q);
				`CHK("write zero", f, q)
				wr(IDX_IRQ_FLAGS, 8'h01);
				rd(IDX_IRQ_FLAGS, q);
				`CHK("write one", f & 8'h02, q)
			end
			rd16(IDX_RESULT, v);
			`CHK("result", e, v)
			rd(IDX_IRQ_FLAGS, q);
			`CHK("read clear", 8'h00, q)
		end
		`CHK("full scale", ACC_LIMIT, v)
		$display("end window");
		wr(IDX_EVENT, 8'h00);
		event_i <= 1'b1;
		@(posedge clk_i);
		event_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK("event off", 1'b0, sample_req_o)
		wr(IDX_EVENT, 8'h01);
		conv(3'h1, 1'b1, 1'b0, e);
		rd16(IDX_RESULT, v);
		`CHK("event result", e, v)
		wr(IDX_HALT, 8'h00);
		wr(IDX_ACCUM, 8'h00);
		wr(IDX_TRIGGER, 8'h01);
		debug_halt_i <= 1'b1;
		sample_done_i <= 1'b1;
		@(posedge clk_i);
		sample_done_i <= 1'b0;
		`CHK("halted", 1'b0, sample_req_o)
		debug_halt_i <= 1'b0;
		samp(10'h155, 1'b0, 1'b0);
		rd16(IDX_RESULT, v);
		`CHK("halt result", 16'h0155, v)
		wr(IDX_HALT, 8'h01);
		wr(IDX_TRIGGER, 8'h01);
		debug_halt_i <= 1'b1;
		samp(10'h2aa, 1'b0, 1'b0);
		debug_halt_i <= 1'b0;
		rd16(IDX_RESULT, v);
		`CHK("run halted", 16'h02aa, v)
		wr(IDX_INPUT_SELECT, 8'h05);
		wr(IDX_TRIGGER, 8'h01);
		wr(IDX_INPUT_SELECT, 8'h09);
		`CHK("select held", 5'h05, channel_o)
		samp(10'h001, 1'b0, 1'b0);
		rd(IDX_LATCH, q);
		`CHK("select applied", 5'h09, channel_o)
		wr(IDX_RUN_CONTROL, 8'h02);
		wr(IDX_TRIGGER, 8'h01);
		repeat (3) samp(RAW_MAX, 1'b0, 1'b0);
		#1;
		`CHK("free run", 1'b1, sample_req_o)
		wr(IDX_RUN_CONTROL, 8'h00);
		samp(10'h000, 1'b0, 1'b0);
		rd(IDX_TRIGGER, q);
		`CHK("free stop", 8'h00, q)
		$display("end conversion");
		end_of_test;
	end
endmodule : tb
